// file: rtl/dacr_regs.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dacr_cfg.svh"
// Behaviour
// - Count self-test forward errors in eight bits, sticking at 255.
// - Clear error count on power-down low or when a new self-test starts.
// - I2C master SCL high lasts the programmed count of 50 ns units, reset 0x83.
// - I2C master SCL low lasts the programmed count of 50 ns units, reset 0x84.
// - Low-time count also sets SDA setup before releasing stretched SCL.
// - Bit 7 set blocks forward-channel loads of the audio path register.
// - Aux audio bit turns GPIO1 into word select, GPIO0 into data.
// - Audio disable bit turns off all serial audio outputs.
// - Surround bit picks 5.1/7.1 audio, else two or four channels.
// - In repeater mode, in-band detected audio mode may override surround.
// - Timing mode bit: zero data-enable only, one sync-driven timing.
// - Sync and data-enable polarity bits: zero active high, one low.
// - Dither stage enable bits turn stages on when one.
// - High-dither stage bits are inverted: zero enables, one disables.
// - Two-bit page selects config, red, green or blue table.
// - White-balance correction applies only while its enable is one.
// - Lookup-table reload is allowed only while reload enable is one.
// - With PLL override set, enable bit zero runs PLL, one stops it.
// - Clock edge bit: zero falling-edge strobe, one rising-edge strobe.
// - Self-test enable zero idles, one starts a run and gates counting.

module dacr_regs (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Device status inputs
  input  wire logic              power_down_n,
  input  wire logic              selftest_error,
  input  wire logic              repeater_mode,
  input  wire logic              inband_surround_valid,
  input  wire logic              inband_surround,
  // Forward-channel register load
  input  wire logic              fwd_load_valid,
  input  wire logic [7:0]        fwd_load_data,
  // I2C timing
  input  wire logic              scl_master_enable,
  input  wire logic              sda_setup_start,
  output logic                   scl_master_out,
  output logic                   scl_release,
  // Control outputs
  output logic                   selftest_run_enable,
  output dacr_pkg::dacr_ctrl_t   ctrl
);

  // ---------------------------------------------------------------
  // Register storage and bus state
  // ---------------------------------------------------------------
  logic [7:0]  err_cnt_reg;
  logic        st_en_reg;
  logic [7:0]  hi_time_reg;
  logic [7:0]  lo_time_reg;
  logic [7:0]  aud_path_reg;
  logic [7:0]  disp_dith_reg;
  logic [7:0]  cbal_reg;
  logic [7:0]  aud_clk_reg;
  logic        aw_hold_reg;
  logic [5:0]  aw_idx_reg;
  logic        aw_hit_reg;
  logic        w_hold_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane0_reg;

  // ---------------------------------------------------------------
  // Write channel decode
  // ---------------------------------------------------------------
  wire         aw_take   = s_axi_awvalid & s_axi_awready;
  wire         w_take    = s_axi_wvalid & s_axi_wready;
  wire         aw_have   = aw_hold_reg | aw_take;
  wire         w_have    = w_hold_reg | w_take;
  wire         wr_fire   = aw_have & w_have & ~s_axi_bvalid;
  wire [5:0]   wr_idx    = aw_take ? s_axi_awaddr[7:2] : aw_idx_reg;
  wire         wr_in_rng = aw_take ? (s_axi_awaddr[31:8] == 24'h000000) : aw_hit_reg;
  wire [7:0]   wr_data   = w_take ? s_axi_wdata[7:0] : w_data_reg;
  wire         wr_lane0  = w_take ? s_axi_wstrb[0] : w_lane0_reg;
  wire         wr_hit    = wr_in_rng && (wr_idx >= `DACR_IDX_ST_CTRL)
                           && (wr_idx <= `DACR_IDX_AUD_CLK);
  wire         wr_ok     = wr_fire & wr_hit & wr_lane0;
  wire         aw_hold_next = aw_have & ~wr_fire;
  wire         w_hold_next  = w_have & ~wr_fire;
  wire         bvalid_next  = wr_fire | (s_axi_bvalid & ~s_axi_bready);

  // Per-register write strobes
  wire         wr_st   = wr_ok && (wr_idx == `DACR_IDX_ST_CTRL);
  wire         wr_hi   = wr_ok && (wr_idx == `DACR_IDX_HI_TIME);
  wire         wr_lo   = wr_ok && (wr_idx == `DACR_IDX_LO_TIME);
  wire         wr_ap   = wr_ok && (wr_idx == `DACR_IDX_AUD_PATH);
  wire         wr_dd   = wr_ok && (wr_idx == `DACR_IDX_DISP_DITH);
  wire         wr_cb   = wr_ok && (wr_idx == `DACR_IDX_CBAL);
  wire         wr_ac   = wr_ok && (wr_idx == `DACR_IDX_AUD_CLK);

  // ---------------------------------------------------------------
  // Read channel decode
  // ---------------------------------------------------------------
  wire         ar_take  = s_axi_arvalid & s_axi_arready;
  wire [5:0]   rd_idx   = s_axi_araddr[7:2];
  wire         rd_hit   = (s_axi_araddr[31:8] == 24'h000000)
                          && (rd_idx >= `DACR_IDX_ST_CTRL) && (rd_idx <= `DACR_IDX_AUD_CLK);
  wire         rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  // Reserved bits are never stored, so they read back zero
  wire [7:0]   rd_byte =
    (rd_idx == `DACR_IDX_ST_CTRL)   ? {7'h00, st_en_reg} :
    (rd_idx == `DACR_IDX_ERR_CNT)   ? err_cnt_reg :
    (rd_idx == `DACR_IDX_HI_TIME)   ? hi_time_reg :
    (rd_idx == `DACR_IDX_LO_TIME)   ? lo_time_reg :
    (rd_idx == `DACR_IDX_AUD_PATH)  ? aud_path_reg :
    (rd_idx == `DACR_IDX_DISP_DITH) ? disp_dith_reg :
    (rd_idx == `DACR_IDX_CBAL)      ? cbal_reg :
    (rd_idx == `DACR_IDX_AUD_CLK)   ? aud_clk_reg : 8'h00;

  // ---------------------------------------------------------------
  // Self-test error counter
  // ---------------------------------------------------------------
  // A run starts on a 0 to 1 write of the enable
  wire         st_start = wr_st & wr_data[`DACR_B_ST_EN] & ~st_en_reg;
  wire         err_clr  = ~power_down_n | st_start;
  wire         err_inc  = st_en_reg & selftest_error
                          & (err_cnt_reg != `DACR_ERR_CNT_MAX);
  wire [7:0]   err_cnt_next = err_clr ? `DACR_RST_ERR_CNT :
                              err_inc ? err_cnt_reg + 8'h01 : err_cnt_reg;

  // Forward-channel load is refused while the block bit is set; bus write wins
  wire         fwd_ok  = fwd_load_valid & ~aud_path_reg[`DACR_B_BLOCK_FWD];
  wire [7:0]   aud_path_next = wr_ap  ? (wr_data & `DACR_MSK_AUD_PATH) :
                               fwd_ok ? (fwd_load_data & `DACR_MSK_AUD_PATH) :
                               aud_path_reg;

  // Bus state and the counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg   <= 1'b0;
      aw_idx_reg    <= 6'h00;
      aw_hit_reg    <= 1'b0;
      w_hold_reg    <= 1'b0;
      w_data_reg    <= 8'h00;
      w_lane0_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DACR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DACR_RESP_OKAY;
      err_cnt_reg   <= `DACR_RST_ERR_CNT;
    end else begin
      aw_hold_reg   <= aw_hold_next;
      w_hold_reg    <= w_hold_next;
      if (aw_take) begin
        aw_idx_reg <= s_axi_awaddr[7:2];
        aw_hit_reg <= (s_axi_awaddr[31:8] == 24'h000000);
      end
      if (w_take) begin
        w_data_reg  <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      // Each channel reopens only once its response has been taken
      s_axi_awready <= ~aw_hold_next & ~bvalid_next;
      s_axi_wready  <= ~w_hold_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (wr_fire) begin
        s_axi_bresp <= wr_hit ? `DACR_RESP_OKAY : `DACR_RESP_SLVERR;
      end
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
        s_axi_rresp <= rd_hit ? `DACR_RESP_OKAY : `DACR_RESP_SLVERR;
      end
      err_cnt_reg <= err_cnt_next;
    end
  end

  // Writable registers; only unreserved bits are kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_en_reg     <= 1'b0;
      hi_time_reg   <= `DACR_RST_HI_TIME;
      lo_time_reg   <= `DACR_RST_LO_TIME;
      aud_path_reg  <= `DACR_RST_ZERO;
      disp_dith_reg <= `DACR_RST_ZERO;
      cbal_reg      <= `DACR_RST_ZERO;
      aud_clk_reg   <= `DACR_RST_ZERO;
    end else begin
      if (wr_st) st_en_reg <= wr_data[`DACR_B_ST_EN];
      if (wr_hi) hi_time_reg <= wr_data;
      if (wr_lo) lo_time_reg <= wr_data;
      aud_path_reg <= aud_path_next;
      if (wr_dd) disp_dith_reg <= wr_data;
      if (wr_cb) cbal_reg <= wr_data & `DACR_MSK_CBAL;
      if (wr_ac) aud_clk_reg <= wr_data & `DACR_MSK_AUD_CLK;
    end
  end

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  dacr_pkg::dacr_ctrl_t ctrl_next;
  // Repeater may follow the in-band mode instead of the stored bit
  wire         surround_eff = (repeater_mode & inband_surround_valid) ? inband_surround
                              : aud_path_reg[`DACR_B_SURROUND];
  wire [1:0]   wb_page = cbal_reg[7:6];

  // Decode of the stored fields and the repeater surround override, registered below
  always_comb begin
    ctrl_next.aux_audio_on_gpio        = aud_path_reg[`DACR_B_AUX_AUDIO];
    ctrl_next.audio_outputs_on         = ~aud_path_reg[`DACR_B_AUD_OFF];
    ctrl_next.surround_on              = surround_eff;
    ctrl_next.sync_timing_mode         = disp_dith_reg[`DACR_B_SYNC_MODE];
    ctrl_next.horizontal_sync_low      = disp_dith_reg[`DACR_B_HS_POL];
    ctrl_next.vertical_sync_low        = disp_dith_reg[`DACR_B_VS_POL];
    ctrl_next.video_data_enable_low    = disp_dith_reg[`DACR_B_DE_POL];
    ctrl_next.dither_stage_two_on      = disp_dith_reg[`DACR_B_DITH2];
    ctrl_next.dither_stage_one_on      = disp_dith_reg[`DACR_B_DITH1];
    ctrl_next.high_dither_stage_two_on = ~disp_dith_reg[`DACR_B_HDITH2];
    ctrl_next.high_dither_stage_one_on = ~disp_dith_reg[`DACR_B_HDITH1];
    ctrl_next.wb_page_onehot           = 4'h1 << wb_page;
    ctrl_next.wb_correct_on            = cbal_reg[`DACR_B_WB_EN];
    ctrl_next.lut_reload_allow         = cbal_reg[`DACR_B_LUT_RELOAD];
    // PLL runs unless overridden and told off
    ctrl_next.audio_pll_run            = ~(aud_clk_reg[`DACR_B_PLL_OVR]
                                           & aud_clk_reg[`DACR_B_PLL_OFF]);
    ctrl_next.audio_strobe_rising      = aud_clk_reg[`DACR_B_CLK_EDGE];
  end

  // Registered controls keep outputs glitch-free at one cycle of lag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                <= '0;
      selftest_run_enable <= 1'b0;
    end else begin
      ctrl                <= ctrl_next;
      selftest_run_enable <= st_en_reg;
    end
  end

  // ---------------------------------------------------------------
  // I2C master SCL generator and slave SDA setup timer
  // ---------------------------------------------------------------
  dacr_pkg::dacr_scl_state_t   scl_st_reg;
  dacr_pkg::dacr_setup_state_t su_st_reg;
  logic [7:0]  unit_cnt_reg;
  logic [7:0]  scl_cnt_reg;
  logic [7:0]  su_cnt_reg;

  // One tick per 50 ns unit; a count of zero is treated as one unit
  wire         unit_tick = (unit_cnt_reg == 8'((`DACR_SCL_UNIT_CYC) - 1));
  wire [7:0]   hi_limit  = (hi_time_reg == 8'h00) ? 8'h01 : hi_time_reg;
  wire [7:0]   lo_limit  = (lo_time_reg == 8'h00) ? 8'h01 : lo_time_reg;
  wire         scl_done  = unit_tick && ((scl_cnt_reg + 8'h01) >= (scl_st_reg ==
                           dacr_pkg::DACR_SCL_HIGH ? hi_limit : lo_limit));
  wire         su_done   = unit_tick && ((su_cnt_reg + 8'h01) >= lo_limit);

  // Unit prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn || unit_tick) unit_cnt_reg <= 8'h00;
    else unit_cnt_reg <= unit_cnt_reg + 8'h01;
  end

  // SCL phases follow the high and low counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_st_reg     <= dacr_pkg::DACR_SCL_OFF;
      scl_cnt_reg    <= 8'h00;
      scl_master_out <= 1'b1;
    end else begin
      case (scl_st_reg)
        dacr_pkg::DACR_SCL_OFF: begin
          scl_cnt_reg <= 8'h00;
          if (scl_master_enable) scl_st_reg <= dacr_pkg::DACR_SCL_HIGH;
        end
        dacr_pkg::DACR_SCL_HIGH, dacr_pkg::DACR_SCL_LOW: begin
          if (!scl_master_enable) begin
            scl_st_reg  <= dacr_pkg::DACR_SCL_OFF;
            scl_cnt_reg <= 8'h00;
          end else if (scl_done) begin
            scl_cnt_reg <= 8'h00;
            scl_st_reg  <= (scl_st_reg == dacr_pkg::DACR_SCL_HIGH) ?
                           dacr_pkg::DACR_SCL_LOW : dacr_pkg::DACR_SCL_HIGH;
          end else if (unit_tick) begin
            scl_cnt_reg <= scl_cnt_reg + 8'h01;
          end
        end
        default: scl_st_reg <= dacr_pkg::DACR_SCL_OFF;
      endcase
      scl_master_out <= (scl_st_reg != dacr_pkg::DACR_SCL_LOW);
    end
  end

  // SDA setup before a stretched SCL is let go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      su_st_reg   <= dacr_pkg::DACR_SU_IDLE;
      su_cnt_reg  <= 8'h00;
      scl_release <= 1'b0;
    end else begin
      scl_release <= 1'b0;
      case (su_st_reg)
        dacr_pkg::DACR_SU_IDLE: begin
          su_cnt_reg <= 8'h00;
          if (sda_setup_start) su_st_reg <= dacr_pkg::DACR_SU_WAIT;
        end
        dacr_pkg::DACR_SU_WAIT: begin
          if (su_done) begin
            scl_release <= 1'b1;
            su_st_reg   <= dacr_pkg::DACR_SU_IDLE;
          end else if (unit_tick) begin
            su_cnt_reg <= su_cnt_reg + 8'h01;
          end
        end
        default: su_st_reg <= dacr_pkg::DACR_SU_IDLE;
      endcase
    end
  end

endmodule

// file: shared/dacr_cfg.svh
`ifndef DACR_CFG_SVH
`define DACR_CFG_SVH

// ---------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define DACR_IDX_ST_CTRL   6'h24
`define DACR_IDX_ERR_CNT   6'h25
`define DACR_IDX_HI_TIME   6'h26
`define DACR_IDX_LO_TIME   6'h27
`define DACR_IDX_AUD_PATH  6'h28
`define DACR_IDX_DISP_DITH 6'h29
`define DACR_IDX_CBAL      6'h2a
`define DACR_IDX_AUD_CLK   6'h2b

// ---------------------------------------------------------------
// Reset values and writable-bit masks
// ---------------------------------------------------------------
`define DACR_RST_ERR_CNT   8'h00
`define DACR_RST_HI_TIME   8'h83
`define DACR_RST_LO_TIME   8'h84
`define DACR_RST_ZERO      8'h00
`define DACR_MSK_ST_CTRL   8'h01
`define DACR_MSK_AUD_PATH  8'h8d
`define DACR_MSK_CBAL      8'hf0
`define DACR_MSK_AUD_CLK   8'hc1
`define DACR_ERR_CNT_MAX   8'hff

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DACR_B_ST_EN       0
`define DACR_B_BLOCK_FWD   7
`define DACR_B_AUX_AUDIO   3
`define DACR_B_AUD_OFF     2
`define DACR_B_SURROUND    0
`define DACR_B_SYNC_MODE   7
`define DACR_B_HS_POL      6
`define DACR_B_VS_POL      5
`define DACR_B_DE_POL      4
`define DACR_B_DITH2       3
`define DACR_B_DITH1       2
`define DACR_B_HDITH2      1
`define DACR_B_HDITH1      0
`define DACR_B_WB_EN       5
`define DACR_B_LUT_RELOAD  4
`define DACR_B_PLL_OVR     7
`define DACR_B_PLL_OFF     6
`define DACR_B_CLK_EDGE    0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DACR_CLK_MHZ       20
`define DACR_SCL_UNIT_NS   50
`define DACR_SCL_UNIT_CYC  ((`DACR_SCL_UNIT_NS * `DACR_CLK_MHZ) / 1000)

`define DACR_RESP_OKAY     2'b00
`define DACR_RESP_SLVERR   2'b10

`endif

// file: shared/dacr_pkg.sv
package dacr_pkg;

  // SCL master phase
  typedef enum logic [1:0] {
    DACR_SCL_OFF,
    DACR_SCL_HIGH,
    DACR_SCL_LOW
  } dacr_scl_state_t;

  // Slave SDA setup before SCL release
  typedef enum logic {
    DACR_SU_IDLE,
    DACR_SU_WAIT
  } dacr_setup_state_t;

  // Decoded controls handed to the data paths
  typedef struct packed {
    logic       aux_audio_on_gpio;
    logic       audio_outputs_on;
    logic       surround_on;
    logic       sync_timing_mode;
    logic       horizontal_sync_low;
    logic       vertical_sync_low;
    logic       video_data_enable_low;
    logic       dither_stage_two_on;
    logic       dither_stage_one_on;
    logic       high_dither_stage_two_on;
    logic       high_dither_stage_one_on;
    logic [3:0] wb_page_onehot;
    logic       wb_correct_on;
    logic       lut_reload_allow;
    logic       audio_pll_run;
    logic       audio_strobe_rising;
  } dacr_ctrl_t;

endpackage

// file: verification/dacr_link_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// Self-test engine and forward-channel source
// ------------------------------------------
module dacr_link_model (
  input wire logic aclk,
  output logic     selftest_error,
  output logic     fwd_load_valid,
  output logic [7:0] fwd_load_data
);
  initial begin
    selftest_error = 1'b0;
    fwd_load_valid = 1'b0;
    fwd_load_data = 8'h00;
  end
  // One error per cycle held high
  task automatic send_errors(input int n);
    repeat (n) @(posedge aclk) selftest_error <= 1'b1;
    @(posedge aclk) selftest_error <= 1'b0;
  endtask
  // Released data shows the inverse so a stale byte cannot pass
  task automatic send_load(input logic [7:0] v);
    @(posedge aclk);
    fwd_load_valid <= 1'b1;
    fwd_load_data <= v;
    @(posedge aclk);
    fwd_load_valid <= 1'b0;
    fwd_load_data <= ~v;
  endtask
endmodule

// file: verification/dacr_regs_props.sv
`timescale 1ns/1ps
// ------------------------------------------
// Port checker for the register slice
// ------------------------------------------
module dacr_regs_props (
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Bus
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_araddr,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  // Timing and controls
  input wire logic                 scl_master_enable,
  input wire logic                 scl_master_out,
  input wire logic                 scl_release,
  input wire logic                 repeater_mode,
  input wire logic                 inband_surround_valid,
  input wire logic                 inband_surround,
  input wire dacr_pkg::dacr_ctrl_t ctrl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken, and block new requests meanwhile
  a_bv_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_rv_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_rd_unmap: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:8] != 24'h0
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  // Idle generator leaves the clock line high
  a_scl_idle: assert property (!scl_master_enable [*3] |-> scl_master_out)
    else $error("clock line low while idle");
  a_rel_pulse: assert property (scl_release |=> !scl_release)
    else $error("release longer than one cycle");
  a_surr_ovr: assert property (repeater_mode && inband_surround_valid
    |=> ctrl.surround_on == $past(inband_surround)) else $error("surround override missed");
endmodule
bind dacr_regs dacr_regs_props i_props (.*);

// file: verification/dacr_regs_tb.sv
`timescale 1ns/1ps
module dacr_regs_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic power_down_n, selftest_error, repeater_mode, inband_surround_valid, inband_surround;
  logic fwd_load_valid, scl_master_enable, sda_setup_start, scl_master_out, scl_release;
  logic selftest_run_enable;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] fwd_load_data, mdl [8];
  dacr_pkg::dacr_ctrl_t ctrl;
  int err_total, n_checks, n, cnt;
  const logic [7:0] msk [8] = '{8'h01, 8'h00, 8'hff, 8'hff, 8'h8d, 8'hff, 8'hf0, 8'hc1};
  const logic [7:0] rstv [8] = '{8'h00, 8'h00, 8'h83, 8'h84, 8'h00, 8'h00, 8'h00, 8'h00};
  dacr_regs i_dut (.*);
  dacr_link_model i_link (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task give_verdict;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task hang;
    err_total++;
    give_verdict();
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] v);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 100 && !dn; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        dn = 1'b1;
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!dn) hang();
  endtask
  task rd(input logic [31:0] a, output logic [31:0] v);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 100 && !dn; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dn = 1'b1;
        v = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!dn) hang();
  endtask
  // Expected decoded controls, in the struct's field order
  function automatic logic [31:0] exp_ctrl();
    logic [7:0] p, t, c, k;
    p = mdl[4];
    t = mdl[5];
    c = mdl[6];
    k = mdl[7];
    return 32'({p[3], ~p[2], p[0], t[7:2], ~t[1:0], 4'b0001 << c[7:6], c[5:4],
                ~(k[7] & k[6]), k[0]});
  endfunction
  // Reads every register and compares all against the model
  task chk_all;
    for (int k = 0; k < 8; k++) begin
      rd(32'h90 + 4 * k, d);
      chk(d, {24'h0, (k == 1) ? cnt[7:0] : mdl[k]});
    end
    chk(32'(ctrl), exp_ctrl());
  endtask
  // Counts one level run; the first sample is already seen
  task meas(input logic lvl, output int r);
    logic dn;
    dn = 1'b0;
    r = 1;
    for (int i = 0; i < 600 && !dn; i++) begin
      @(posedge aclk);
      if (scl_master_out !== lvl) dn = 1'b1;
      else r++;
    end
    if (!dn) hang();
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {repeater_mode, inband_surround_valid, inband_surround} = 3'h0;
    {scl_master_enable, sda_setup_start, aresetn} = 3'h0;
    s_axi_wstrb = 4'hf;
    power_down_n = 1'b1;
    void'($urandom(32'hc5ac3636));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = rstv;
    cnt = 0;
    chk_all();
    // Random contents everywhere but the self-test control, read-only count included
    repeat (3) for (int k = 1; k < 8; k++) begin
      d = $urandom;
      wr(32'h90 + 4 * k, d);
      chk(rsp, 2'b00);
      mdl[k] = d[7:0] & msk[k];
      chk_all();
    end
    // A write with no byte lane enabled is answered but stores nothing
    s_axi_wstrb <= 4'h0;
    wr(32'h98, {24'h0, ~mdl[2]});
    s_axi_wstrb <= 4'hf;
    chk(rsp, 2'b00);
    chk_all();
    wr(32'h200, $urandom);
    chk(rsp, 2'b10);
    rd(32'h300, d);
    chk(d, 32'h0);
    // Saturating error count, read only once the run has ended
    wr(32'h90, 32'h1);
    @(posedge aclk);
    chk(selftest_run_enable, 1'b1);
    n = 250 + $urandom % 20;
    i_link.send_errors(n);
    cnt = (n > 255) ? 255 : n;
    wr(32'h90, 32'h0);
    mdl[0] = 8'h00;
    chk_all();
    wr(32'h90, 32'h1);
    i_link.send_errors(3);
    wr(32'h90, 32'h0);
    cnt = 3;
    chk_all();
    power_down_n <= 1'b0;
    @(posedge aclk) power_down_n <= 1'b1;
    cnt = 0;
    chk_all();
    // Forward-channel load taken, then refused once blocked
    wr(32'ha0, 32'h0);
    // Bit 0 forced on so an ignored load cannot match the cleared register
    d = ($urandom & 32'h7f) | 32'h1;
    i_link.send_load(d[7:0]);
    mdl[4] = d[7:0] & 8'h8d;
    chk_all();
    wr(32'ha0, 32'h80);
    mdl[4] = 8'h80;
    i_link.send_load(8'h0d);
    chk_all();
    // Clock generator high and low widths
    wr(32'h98, 32'h3);
    wr(32'h9c, 32'h2);
    scl_master_enable <= 1'b1;
    meas(1'b1, n);
    meas(1'b0, n);
    chk(n, 2);
    meas(1'b1, n);
    chk(n, 3);
    scl_master_enable <= 1'b0;
    // Setup interval before releasing a stretched clock
    wr(32'h9c, 32'h5);
    sda_setup_start <= 1'b1;
    @(posedge aclk) sda_setup_start <= 1'b0;
    n = 1;
    while (scl_release !== 1'b1 && n < 50) @(posedge aclk) n++;
    chk(n >= 5 && n <= 7, 1'b1);
    // Repeater override of the surround mode both ways
    // Surround comes only from the in-band path here, which rides the data island
    {repeater_mode, inband_surround_valid, inband_surround} <= 3'h7;
    repeat (3) @(posedge aclk);
    chk(ctrl.surround_on, 1'b1);
    inband_surround <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(ctrl.surround_on, 1'b0);
    give_verdict();
  end
endmodule
